/* File: bench/jnp_host.sv */
/*
 * Programmer model: drives tck, tms and tdi and samples tdo.
 * Assumes clk_sys at 100 ns; tck runs at 800 ns only within the host tasks and rests low.
 */
`timescale 1ns/1ps
`default_nettype none
module jnp_host (
	input wire logic clk_sys,
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	input wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// tdo is taken just before the rise, where the device keeps it valid
	task automatic tick(input logic m, input logic d, output logic o);
		@(posedge clk_sys);
		tms <= m;
		tdi <= d;
		repeat (3) @(posedge clk_sys);
		o = tdo;
		tck <= 1'b1;
		repeat (4) @(posedge clk_sys);
		tck <= 1'b0;
	endtask : tick

	task automatic tap_reset();
		logic o;
		repeat (5) tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b1, o);
	endtask : tap_reset

	// From idle through one IR or DR scan back to idle; tdi toggles when unused
	task automatic scan(input logic ir, input int n, input logic [15:0] d, output logic [15:0] q);
		logic o;
		q = '0;
		tick(1'b1, ~tdi, o);
		if (ir) tick(1'b1, ~tdi, o);
		tick(1'b0, ~tdi, o);
		tick(1'b0, ~tdi, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, d[i], o);
			q[i] = o;
		end
		tick(1'b1, ~d[n-1], o);
		tick(1'b0, d[n-1], o);
	endtask : scan

	task automatic idle(input int n);
		logic o;
		repeat (n) tick(1'b0, ~tdi, o);
	endtask : idle
endmodule : jnp_host
`default_nettype wire

/* File: bench/jnp_prog_port_bench.sv */
/*
 * Self-checking bench for the programming port: reset chain, enable key,
 * commands, page load and page read.
 * Assumes the design header and package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "jnp_consts.svh"
module jnp_prog_port_bench;
	localparam int TMO = 40;
	logic clk_sys, rst_n, tck, tms, tdi, tdo, tdo_oe, core_reset_n, prog_mode, nvm_exec;
	logic pg_wr, pg_wr_hi, pc_inc;
	logic [6:0] nvm_cmd_op;
	logic [7:0] nvm_cmd_arg, pg_wr_data, flash_lo, flash_hi;
	logic [14:0] nvm_result;
	logic [15:0] q;
	logic [31:0] r;
	logic [8:0] wq[$];
	int n_fail = 0, compares = 0, n_exec = 0, n_inc = 0, n_oe = 0, e, f, seed = 64030;
	// Command table spans erase, write, read and EEPROM sequences
	logic [14:0] cmds [16] = '{15'h2310, 15'h0BA5, 15'h073C, 15'h035A, 15'h13C3, 15'h1796, 15'h3700,
		15'h7700, 15'h3500, 15'h3180, 15'h3380, 15'h2302, 15'h3200, 15'h3600, 15'h2311, 15'h3100};

	jnp_prog_port #(.TIMEOUT_CYC(TMO)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .core_reset_n(core_reset_n), .prog_mode(prog_mode), .nvm_cmd_op(nvm_cmd_op),
		.nvm_cmd_arg(nvm_cmd_arg), .nvm_exec(nvm_exec), .nvm_result(nvm_result), .pg_wr(pg_wr),
		.pg_wr_hi(pg_wr_hi), .pg_wr_data(pg_wr_data), .pc_inc(pc_inc), .flash_lo(flash_lo), .flash_hi(flash_hi));
	jnp_host host (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Pulses are counted here so a missing or doubled strobe shows up
	always @(posedge clk_sys) begin
		if (nvm_exec === 1'b1) n_exec++;
		if (pc_inc === 1'b1) n_inc++;
		if (pg_wr === 1'b1) wq.push_back({pg_wr_hi, pg_wr_data});
	end

	// Each shifted bit is one tck rise with the output enabled
	always @(posedge tck) begin
		if (tdo_oe === 1'b1) n_oe++;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	initial begin
		#3000000;
		n_fail++;
		end_of_test();
	end

	initial begin
		rst_n = 1'b0;
		nvm_result = '0;
		flash_lo = '0;
		flash_hi = '0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk(16'(prog_mode), 16'h0000);
		chk(16'(core_reset_n), 16'h0001);
		host.tap_reset();
		host.scan(1'b1, 4, 16'(`JNP_IR_RESET), q);
		host.scan(1'b0, 1, 16'h0001, q);
		chk(16'(core_reset_n), 16'h0000);
		$display("test reset chain done");
		host.scan(1'b1, 4, 16'(`JNP_IR_ENABLE), q);
		chk(q, 16'h0001);
		r = $random(seed);
		host.scan(1'b0, 16, `JNP_EN_KEY ^ (r[15:0] | 16'h0001), q);
		chk(16'(prog_mode), 16'h0000);
		host.scan(1'b0, 16, `JNP_EN_KEY, q);
		chk(16'(prog_mode), 16'h0001);
		host.scan(1'b1, 4, 16'(`JNP_IR_RESET), q);
		host.scan(1'b0, 1, 16'h0000, q);
		// Scan ends well inside the time-out window, which outlasts three tck periods
		chk(16'(core_reset_n), 16'h0000);
		repeat (TMO) @(posedge clk_sys);
		chk(16'(core_reset_n), 16'h0001);
		$display("test enable done");
		host.scan(1'b1, 4, 16'(`JNP_IR_CMD), q);
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			nvm_result <= r[14:0];
			@(posedge clk_sys);
			f = n_oe;
			host.scan(1'b0, 15, {1'b0, cmds[i]}, q);
			chk(q, {1'b0, r[14:0]});
			chk(16'(n_oe - f), 16'h000F);
			chk({1'b0, nvm_cmd_op, nvm_cmd_arg}, {1'b0, cmds[i]});
			e = n_exec;
			host.idle(2);
			// The last pulse is counted at the edge the task returns on
			@(posedge clk_sys);
			chk(16'(n_exec - e), 16'h0002);
		end
		// Poll repeats until the completion bit comes back set
		nvm_result <= '0;
		host.scan(1'b0, 15, 16'h3380, q);
		for (int k = 0; k < 8 && q[9] !== 1'b1; k++) begin
			if (k == 2) begin
				nvm_result <= 15'h0200;
			end
			host.scan(1'b0, 15, 16'h3380, q);
		end
		chk(q, 16'h0200);
		$display("test commands done");
		host.scan(1'b1, 4, 16'(`JNP_IR_PGLOAD), q);
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			e = n_inc;
			wq.delete();
			host.scan(1'b0, 8, {8'h00, r[7:0]}, q);
			// The buffer write trails the update by a few system clocks
			repeat (3) @(posedge clk_sys);
			chk(16'(wq.size()), 16'h0001);
			chk({7'h00, wq[0]}, {7'h00, i[0], r[7:0]});
			chk(16'(n_inc - e), 16'(i > 0 && i[0] == 1'b0));
		end
		$display("test page load done");
		host.scan(1'b1, 4, 16'(`JNP_IR_PGREAD), q);
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			flash_lo <= r[7:0];
			flash_hi <= r[15:8];
			@(posedge clk_sys);
			e = n_inc;
			host.scan(1'b0, 8, 16'h0000, q);
			chk(q, {8'h00, i[0] ? r[15:8] : r[7:0]});
			chk(16'(n_inc - e), 16'(i[0]));
		end
		$display("test page read done");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(16'(prog_mode), 16'h0000);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		host.tap_reset();
		host.scan(1'b1, 4, 16'(`JNP_IR_RESET), q);
		host.scan(1'b0, 1, 16'h0001, q);
		host.scan(1'b1, 4, 16'(`JNP_IR_ENABLE), q);
		host.scan(1'b0, 16, `JNP_EN_KEY, q);
		chk(q, 16'h0000);
		chk(16'(prog_mode), 16'h0001);
		// Shifting zeros reads the key back out of the enable register and leaves programming mode
		host.scan(1'b0, 16, 16'h0000, q);
		chk(q, `JNP_EN_KEY);
		chk(16'(prog_mode), 16'h0000);
		$display("test reset and leave done");
		end_of_test();
	end
endmodule : jnp_prog_port_bench
`default_nettype wire

/* File: logic/jnp_consts.svh */
/*
 * Constants for the test-port programming block: instruction codes, register
 * widths, the enable key and timing counts.
 * Assumes a 10 MHz system clock and a test clock well below it.
 */
`ifndef JNP_CONSTS_SVH
`define JNP_CONSTS_SVH

`define JNP_IR_W 4
`define JNP_IR_CAPTURE 4'h1
`define JNP_IR_ENABLE 4'h4
`define JNP_IR_CMD 4'h5
`define JNP_IR_PGLOAD 4'h6
`define JNP_IR_PGREAD 4'h7
`define JNP_IR_RESET 4'hC
`define JNP_IR_BYPASS 4'hF

`define JNP_EN_W 16
`define JNP_EN_KEY 16'hA370
`define JNP_CMD_W 15
`define JNP_BYTE_W 8
`define JNP_OPC_W 7
`define JNP_OPC_LSB 8

`define JNP_CLK_NS 100
`define JNP_TCK_NS 800
`define JNP_PGLOAD_MAX_TCK 11
`define JNP_PGLOAD_MAX_NS (`JNP_PGLOAD_MAX_TCK * `JNP_TCK_NS)
`define JNP_PGLOAD_MAX_CYC (`JNP_PGLOAD_MAX_NS / `JNP_CLK_NS)
`define JNP_RST_TIMEOUT_NS 4100
`define JNP_RST_TIMEOUT_CYC ((`JNP_RST_TIMEOUT_NS + `JNP_CLK_NS - 1) / `JNP_CLK_NS)

`endif

/* File: logic/jnp_pkg.sv */
/*
 * Types of the test-port programming block.
 * Assumes the constants header is compiled alongside.
 */
package jnp_pkg;
	typedef enum logic [3:0] {
		JNP_TLR, JNP_IDLE, JNP_SEL_DR, JNP_CAP_DR, JNP_SH_DR, JNP_EX1_DR, JNP_PAU_DR, JNP_EX2_DR,
		JNP_UPD_DR, JNP_SEL_IR, JNP_CAP_IR, JNP_SH_IR, JNP_EX1_IR, JNP_PAU_IR, JNP_EX2_IR, JNP_UPD_IR
	} jnp_tap_type;
endpackage : jnp_pkg

/* File: logic/jnp_prog_port.sv */
/*
 * Programming side of the test access port: TAP controller and its registers.
 * Assumes the memory controller answers on nvm_result and flash_lo/hi on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "jnp_consts.svh"

// Functional notes
// - IR 0x4 selects 16-bit enable register
// - Update-DR enters programming only on key
// - Enable register clears at power-on reset
// - IR 0x5 selects 15-bit command register
// - Capture-DR loads previous command result
// - Shift-DR moves result out, command in
// - Update applies command, each idle executes
// - IR 0x6 shifts low command byte
// - Update copies byte, writes within 11 TCK
// - Page-load alternates low, high; low first
// - Counter pre-increments before low, not first
// - IR 0x7 captures low then high byte
// - Counter post-increments after each high capture
// - Reset bit asserts core reset, unlatched
// - Release keeps reset for time-out period
// - Chip erase commands, then poll completion
// - Flash write command and address sequence
// - Page program strobe, then completion polling
// - Flash read returns low, then high byte
// - EEPROM write sequence and page strobe
// - All shifts least significant bit first
// - Instruction register is four bits wide
module jnp_prog_port import jnp_pkg::*; #(
	parameter int TIMEOUT_CYC = `JNP_RST_TIMEOUT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	output logic core_reset_n,
	output logic prog_mode,
	output logic [`JNP_OPC_W-1:0] nvm_cmd_op,
	output logic [`JNP_BYTE_W-1:0] nvm_cmd_arg,
	output logic nvm_exec,
	input wire logic [`JNP_CMD_W-1:0] nvm_result,
	output logic pg_wr,
	output logic pg_wr_hi,
	output logic [`JNP_BYTE_W-1:0] pg_wr_data,
	output logic pc_inc,
	input wire logic [`JNP_BYTE_W-1:0] flash_lo,
	input wire logic [`JNP_BYTE_W-1:0] flash_hi
);
	localparam int TMO_W = $clog2(TIMEOUT_CYC + 1);
	function automatic logic [`JNP_OPC_W-1:0] opc_of(input logic [`JNP_CMD_W-1:0] w);
		opc_of = w[`JNP_CMD_W-1:`JNP_OPC_LSB];
	endfunction : opc_of
	function automatic logic [`JNP_BYTE_W-1:0] arg_of(input logic [`JNP_CMD_W-1:0] w);
		arg_of = w[`JNP_BYTE_W-1:0];
	endfunction : arg_of
	logic tck_s, tms_s, tdi_s, tck_d_r, tck_rise, tck_fall;
	jnp_tap_type tap_r, tap_nxt;
	logic [`JNP_IR_W-1:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
	logic [`JNP_EN_W-1:0] en_sh_r, en_sh_nxt;
	logic [`JNP_CMD_W-1:0] cmd_sh_r, cmd_sh_nxt, cmd_app_r, cmd_app_nxt;
	logic byp_r, byp_nxt, rst_chain_r, rst_chain_nxt, tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;
	logic prog_r, prog_nxt, exec_r, exec_nxt, pr_hi_r, pr_hi_nxt, pr_inc_r, pr_inc_nxt;
	logic pl_start, pl_pend_r, pl_pend_nxt, pl_go_r, pl_go_nxt;
	logic pl_hi_r, pl_hi_nxt, pl_first_r, pl_first_nxt;
	logic [`JNP_BYTE_W-1:0] pl_hold_r, pl_hold_nxt;
	logic pg_wr_r, pg_wr_nxt, pg_wr_hi_r, pg_wr_hi_nxt, pl_inc_r, pl_inc_nxt;
	logic [TMO_W-1:0] tmo_r, tmo_nxt;
	jnp_sync #(.WIDTH(3)) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.din({tck, tms, tdi}),
		.dout({tck_s, tms_s, tdi_s})
	);
	// Edges are taken from the synchronised copy, so TMS/TDI share its delay
	assign tck_rise = tck_s & ~tck_d_r;
	assign tck_fall = ~tck_s & tck_d_r;
	// TAP controller, instruction and data registers
	always_comb begin
		tap_nxt = tap_r;
		ir_nxt = ir_r;
		ir_sh_nxt = ir_sh_r;
		en_sh_nxt = en_sh_r;
		cmd_sh_nxt = cmd_sh_r;
		cmd_app_nxt = cmd_app_r;
		byp_nxt = byp_r;
		rst_chain_nxt = rst_chain_r;
		prog_nxt = prog_r;
		exec_nxt = 1'b0;
		pr_hi_nxt = pr_hi_r;
		pr_inc_nxt = 1'b0;
		pl_start = 1'b0;
		tdo_nxt = tdo_r;
		tdo_oe_nxt = tdo_oe_r;
		if (tck_rise) begin
			unique case (tap_r)
				JNP_TLR: tap_nxt = tms_s ? JNP_TLR : JNP_IDLE;
				JNP_IDLE: tap_nxt = tms_s ? JNP_SEL_DR : JNP_IDLE;
				JNP_SEL_DR: tap_nxt = tms_s ? JNP_SEL_IR : JNP_CAP_DR;
				JNP_CAP_DR: tap_nxt = tms_s ? JNP_EX1_DR : JNP_SH_DR;
				JNP_SH_DR: tap_nxt = tms_s ? JNP_EX1_DR : JNP_SH_DR;
				JNP_EX1_DR: tap_nxt = tms_s ? JNP_UPD_DR : JNP_PAU_DR;
				JNP_PAU_DR: tap_nxt = tms_s ? JNP_EX2_DR : JNP_PAU_DR;
				JNP_EX2_DR: tap_nxt = tms_s ? JNP_UPD_DR : JNP_SH_DR;
				JNP_UPD_DR: tap_nxt = tms_s ? JNP_SEL_DR : JNP_IDLE;
				JNP_SEL_IR: tap_nxt = tms_s ? JNP_TLR : JNP_CAP_IR;
				JNP_CAP_IR: tap_nxt = tms_s ? JNP_EX1_IR : JNP_SH_IR;
				JNP_SH_IR: tap_nxt = tms_s ? JNP_EX1_IR : JNP_SH_IR;
				JNP_EX1_IR: tap_nxt = tms_s ? JNP_UPD_IR : JNP_PAU_IR;
				JNP_PAU_IR: tap_nxt = tms_s ? JNP_EX2_IR : JNP_PAU_IR;
				JNP_EX2_IR: tap_nxt = tms_s ? JNP_UPD_IR : JNP_SH_IR;
				JNP_UPD_IR: tap_nxt = tms_s ? JNP_SEL_DR : JNP_IDLE;
			endcase
			unique case (tap_r)
				JNP_TLR: ir_nxt = `JNP_IR_BYPASS;
				JNP_CAP_IR: ir_sh_nxt = `JNP_IR_CAPTURE;
				JNP_SH_IR: ir_sh_nxt = {tdi_s, ir_sh_r[`JNP_IR_W-1:1]};
				JNP_UPD_IR: begin
					ir_nxt = ir_sh_r;
					pr_hi_nxt = 1'b0;
				end
				JNP_CAP_DR: begin
					byp_nxt = 1'b0;
					if (ir_r == `JNP_IR_CMD) begin
						cmd_sh_nxt = nvm_result;
					end else if (ir_r == `JNP_IR_PGREAD && prog_r) begin
						cmd_sh_nxt[`JNP_BYTE_W-1:0] = pr_hi_r ? flash_hi : flash_lo;
						pr_hi_nxt = ~pr_hi_r;
						pr_inc_nxt = pr_hi_r;
					end
				end
				JNP_SH_DR: begin
					unique case (ir_r)
						`JNP_IR_ENABLE: en_sh_nxt = {tdi_s, en_sh_r[`JNP_EN_W-1:1]};
						`JNP_IR_CMD: cmd_sh_nxt = {tdi_s, cmd_sh_r[`JNP_CMD_W-1:1]};
						`JNP_IR_PGLOAD, `JNP_IR_PGREAD: cmd_sh_nxt[`JNP_BYTE_W-1:0] =
							{tdi_s, cmd_sh_r[`JNP_BYTE_W-1:1]};
						`JNP_IR_RESET: rst_chain_nxt = tdi_s;
						default: byp_nxt = tdi_s;
					endcase
				end
				JNP_UPD_DR: begin
					if (ir_r == `JNP_IR_ENABLE) begin
						prog_nxt = (en_sh_r == `JNP_EN_KEY);
					end else if (ir_r == `JNP_IR_CMD && prog_r) begin
						cmd_app_nxt = cmd_sh_r;
					end else if (ir_r == `JNP_IR_PGLOAD && prog_r) begin
						pl_start = 1'b1;
					end
				end
				JNP_IDLE: exec_nxt = prog_r && (ir_r == `JNP_IR_CMD);
				default: ;
			endcase
		end
		if (tck_fall) begin
			tdo_oe_nxt = (tap_r == JNP_SH_DR) || (tap_r == JNP_SH_IR);
			if (tap_r == JNP_SH_IR) begin
				tdo_nxt = ir_sh_r[0];
			end else begin
				unique case (ir_r)
					`JNP_IR_ENABLE: tdo_nxt = en_sh_r[0];
					`JNP_IR_CMD, `JNP_IR_PGLOAD, `JNP_IR_PGREAD: tdo_nxt = cmd_sh_r[0];
					`JNP_IR_RESET: tdo_nxt = rst_chain_r;
					default: tdo_nxt = byp_r;
				endcase
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tck_d_r <= 1'b0;
			tap_r <= JNP_TLR;
			ir_r <= `JNP_IR_BYPASS;
			ir_sh_r <= '0;
			en_sh_r <= '0;
			cmd_sh_r <= '0;
			cmd_app_r <= '0;
			byp_r <= 1'b0;
			rst_chain_r <= 1'b0;
			prog_r <= 1'b0;
			exec_r <= 1'b0;
			pr_hi_r <= 1'b0;
			pr_inc_r <= 1'b0;
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
		end else begin
			tck_d_r <= tck_s;
			tap_r <= tap_nxt;
			ir_r <= ir_nxt;
			ir_sh_r <= ir_sh_nxt;
			en_sh_r <= en_sh_nxt;
			cmd_sh_r <= cmd_sh_nxt;
			cmd_app_r <= cmd_app_nxt;
			byp_r <= byp_nxt;
			rst_chain_r <= rst_chain_nxt;
			prog_r <= prog_nxt;
			exec_r <= exec_nxt;
			pr_hi_r <= pr_hi_nxt;
			pr_inc_r <= pr_inc_nxt;
			tdo_r <= tdo_nxt;
			tdo_oe_r <= tdo_oe_nxt;
		end
	end
	// Page-load write sequence and core reset time-out
	always_comb begin
		pl_pend_nxt = pl_start;
		pl_go_nxt = pl_pend_r;
		pl_hold_nxt = pl_hold_r;
		pl_hi_nxt = pl_hi_r;
		pl_first_nxt = pl_first_r;
		pl_inc_nxt = 1'b0;
		pg_wr_nxt = 1'b0;
		pg_wr_hi_nxt = pg_wr_hi_r;
		tmo_nxt = tmo_r;
		if (tck_rise && tap_r == JNP_UPD_IR) begin
			pl_hi_nxt = 1'b0;
			pl_first_nxt = 1'b1;
		end
		if (pl_start) begin
			pl_hold_nxt = arg_of(cmd_sh_r);
		end
		if (pl_pend_r) begin
			pl_inc_nxt = !pl_hi_r && !pl_first_r;
		end
		if (pl_go_r) begin
			pg_wr_nxt = 1'b1;
			pg_wr_hi_nxt = pl_hi_r;
			pl_hi_nxt = ~pl_hi_r;
			pl_first_nxt = 1'b0;
		end
		// Counting from the release rather than the set keeps a long hold intact
		if (rst_chain_r) begin
			tmo_nxt = TMO_W'(TIMEOUT_CYC);
		end else if (tmo_r != '0) begin
			tmo_nxt = tmo_r - 1'b1;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pl_pend_r <= 1'b0;
			pl_go_r <= 1'b0;
			pl_hold_r <= '0;
			pl_hi_r <= 1'b0;
			pl_first_r <= 1'b1;
			pl_inc_r <= 1'b0;
			pg_wr_r <= 1'b0;
			pg_wr_hi_r <= 1'b0;
			tmo_r <= '0;
		end else begin
			pl_pend_r <= pl_pend_nxt;
			pl_go_r <= pl_go_nxt;
			pl_hold_r <= pl_hold_nxt;
			pl_hi_r <= pl_hi_nxt;
			pl_first_r <= pl_first_nxt;
			pl_inc_r <= pl_inc_nxt;
			pg_wr_r <= pg_wr_nxt;
			pg_wr_hi_r <= pg_wr_hi_nxt;
			tmo_r <= tmo_nxt;
		end
	end
	assign tdo = tdo_r;
	assign tdo_oe = tdo_oe_r;
	// The chain bit drives reset directly; no update stage sits in between
	assign core_reset_n = !(rst_chain_r || tmo_r != '0);
	assign prog_mode = prog_r;
	assign nvm_cmd_op = opc_of(cmd_app_r);
	assign nvm_cmd_arg = arg_of(cmd_app_r);
	assign nvm_exec = exec_r;
	assign pg_wr = pg_wr_r;
	assign pg_wr_hi = pg_wr_hi_r;
	assign pg_wr_data = pl_hold_r;
	assign pc_inc = pl_inc_r | pr_inc_r;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_pl_update;
		tck_rise && tap_r == JNP_UPD_DR && ir_r == `JNP_IR_PGLOAD && prog_r;
	endsequence
	sequence s_pl_write;
		##[1:3] pg_wr_r && pg_wr_data == $past(cmd_sh_r[`JNP_BYTE_W-1:0], 3);
	endsequence
	property p_en_shift;
		tck_rise && tap_r == JNP_SH_DR && ir_r == `JNP_IR_ENABLE |=> en_sh_r[`JNP_EN_W-1] == $past(tdi_s);
	endproperty
	a_en_shift: assert property (p_en_shift) else $error("enable register shift wrong");
	property p_key_match;
		tck_rise && tap_r == JNP_UPD_DR && ir_r == `JNP_IR_ENABLE |=> prog_mode == ($past(en_sh_r) == `JNP_EN_KEY);
	endproperty
	a_key_match: assert property (p_key_match) else $error("programming mode not set by key");
	property p_cmd_shift;
		tck_rise && tap_r == JNP_SH_DR && ir_r == `JNP_IR_CMD |=> cmd_sh_r == {$past(tdi_s), $past(cmd_sh_r[14:1])};
	endproperty
	a_cmd_shift: assert property (p_cmd_shift) else $error("command register shift wrong");
	property p_capture;
		tck_rise && tap_r == JNP_CAP_DR && ir_r == `JNP_IR_CMD |=> cmd_sh_r == $past(nvm_result);
	endproperty
	a_capture: assert property (p_capture) else $error("command result not captured");
	property p_exec;
		tck_rise && tap_r == JNP_IDLE && ir_r == `JNP_IR_CMD && prog_r |=> nvm_exec ##1 !nvm_exec;
	endproperty
	a_exec: assert property (p_exec) else $error("idle did not give one execute pulse");
	property p_pl_write;
		s_pl_update |-> s_pl_write;
	endproperty
	a_pl_write: assert property (p_pl_write) else $error("page-load byte not written");
	property p_pl_alt;
		pg_wr_r |=> pl_hi_r == !$past(pg_wr_hi_r);
	endproperty
	a_pl_alt: assert property (p_pl_alt) else $error("page-load byte order not alternating");
	property p_pl_inc;
		pl_inc_r |=> pg_wr_r && !pg_wr_hi_r;
	endproperty
	a_pl_inc: assert property (p_pl_inc) else $error("pre-increment not followed by low write");
	property p_pr_inc;
		tck_rise && tap_r == JNP_CAP_DR && ir_r == `JNP_IR_PGREAD && prog_r && pr_hi_r |=> pc_inc;
	endproperty
	a_pr_inc: assert property (p_pr_inc) else $error("no increment after high byte read");
	property p_rst_hold;
		$fell(rst_chain_r) |-> !core_reset_n && tmo_r == TMO_W'(TIMEOUT_CYC);
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset released without time-out");
	property p_rst_now;
		tck_rise && tap_r == JNP_SH_DR && ir_r == `JNP_IR_RESET && tdi_s |=> !core_reset_n;
	endproperty
	a_rst_now: assert property (p_rst_now) else $error("reset bit did not hold core in reset");
endmodule : jnp_prog_port
`default_nettype wire

/* File: logic/jnp_sync.sv */
/*
 * Two-stage synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk_sys and may be skewed by a cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module jnp_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			dout <= '0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule : jnp_sync
`default_nettype wire
